// ---- logic/board_regs_pkg.sv ----
// Constants for the board control and status register bank.
// Assumes a byte-wide host I/O port with a 16-bit port address.
package board_regs_pkg;

	// ****************************************
	// Port addresses
	// ****************************************
	localparam logic [15:0] ADDR_SELFTEST_LOW = 16'h0080;
	localparam logic [15:0] ADDR_SELFTEST_HIGH = 16'h0081;
	localparam logic [15:0] ADDR_DEBUG_LOW = 16'h0084;
	localparam logic [15:0] ADDR_DEBUG_HIGH = 16'h0085;
	localparam logic [15:0] ADDR_STATUS_FIRST = 16'h0280;
	localparam logic [15:0] ADDR_STATUS_SECOND = 16'h0281;
	localparam logic [15:0] ADDR_CONTROL_FIRST = 16'h0282;
	localparam logic [15:0] ADDR_CONTROL_SECOND = 16'h0283;
	localparam logic [15:0] ADDR_WRITE_PROTECT = 16'h0284;
	localparam logic [15:0] ADDR_RESET_SOURCE = 16'h0285;
	localparam logic [15:0] ADDR_IRQ_ROUTING = 16'h0286;
	localparam logic [15:0] ADDR_STATUS_THIRD = 16'h0287;
	localparam logic [15:0] ADDR_TYPE_HIGH = 16'h0288;
	localparam logic [15:0] ADDR_REVISION = 16'h0289;
	localparam logic [15:0] ADDR_SLOT_SITE = 16'h028A;
	localparam logic [15:0] ADDR_WATCHDOG = 16'h028C;
	localparam logic [15:0] ADDR_TYPE_LOW = 16'h028D;
	localparam logic [15:0] ADDR_LED_CONFIG = 16'h0290;
	localparam logic [15:0] ADDR_LED_CONTROL = 16'h0291;
	localparam logic [15:0] ADDR_GP_OUTPUTS = 16'h0292;
	localparam logic [15:0] ADDR_GP_INPUTS = 16'h0293;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int STAT_HANDLE_BIT = 7;
	localparam int STAT_BOOT_DONE_BIT = 6;
	localparam int STAT_FLASH_MSB = 5;
	localparam int STAT_FLASH_LSB = 4;
	localparam int STAT_STRAP_MSB = 3;
	localparam int PROT_SYS_BIT = 7;
	localparam int PROT_EEPROM_BIT = 1;
	localparam int PROT_SPI_BIT = 0;
	localparam int RSRC_POWERON_BIT = 7;
	localparam int RSRC_NOLOG_BIT = 5;

	// ****************************************
	// Encodings and reset values
	// ****************************************
	localparam logic [1:0] FLASH_STANDARD = 2'h0;
	localparam logic [1:0] FLASH_RECOVERY = 2'h1;
	localparam logic [1:0] FLASH_EXTERNAL = 2'h2;
	localparam logic [7:0] RST_CONTROL_FIRST = 8'hC4;
	localparam logic [7:0] BOARD_CONTROL_FIRST_WR_MASK = 8'hCC;
	localparam logic [7:0] RST_CONTROL_SECOND = 8'hC4;
	localparam logic [7:0] BOARD_CONTROL_SECOND_WR_MASK = 8'h9B;
	localparam logic [7:0] RST_RESET_SOURCE = 8'h80;
	localparam logic [7:0] RSRC_W1C_MASK = 8'h8F;
	localparam logic [7:0] IRQ_WR_MASK = 8'hF3;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] BOARD_STATUS_THIRD_MASK = 8'h02;
	localparam logic [7:0] SLOT_MASK = 8'h1F;

endpackage : board_regs_pkg

// ---- logic/board_control_status_registers.sv ----
// Byte-wide I/O register bank of the board logic device.
// Assumes single-cycle host read and write strobes synchronous to SYS_CLK.
`timescale 1ns/1ps
module board_control_status_registers #(
	parameter logic [15:0] BOARD_TYPE_CODE = 16'h5A01, // Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h00
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [7:0] IO_WDATA,
	output logic [7:0] IO_RDATA,
	output logic IO_HIT,
	input wire logic EJECTOR_HANDLE_OPEN,
	input wire logic BOOT_STRAP_ONE,
	input wire logic BOOT_STRAP_TWO,
	input wire logic BOOT_STRAP_THREE,
	input wire logic BOOT_STRAP_FOUR,
	input wire logic BACKPLANE_SWITCH_ONE,
	input wire logic BACKPLANE_SWITCH_TWO,
	input wire logic MEZZANINE_SWITCH_ONE,
	input wire logic MEZZANINE_SWITCH_TWO,
	input wire logic BACKPLANE_66_DETECT,
	input wire logic BACKPLANE_PCIX_DETECT,
	input wire logic MEZZANINE_PCIX_DETECT,
	input wire logic [7:0] BACKPLANE_STATUS,
	input wire logic [7:0] BOARD_STATUS_THIRD,
	input wire logic [4:0] SLOT_SITE_NUMBER,
	input wire logic SYS_WRITE_PROTECT,
	input wire logic [7:0] GENERAL_INPUTS,
	input wire logic FIRMWARE_BOOT_DONE,
	input wire logic FLASH_SELECT_REQ,
	input wire logic [1:0] FLASH_SELECT_VALUE,
	output logic [1:0] BOOT_FLASH_SELECTED,
	output logic SELFTEST_DISPLAY_EN,
	output logic [15:0] SELFTEST_CODE,
	output logic [15:0] DEBUG_WORD,
	output logic BACKPLANE_CLK_66,
	output logic BACKPLANE_PCIX_MODE,
	output logic MEZZANINE_BASE_25,
	output logic MEZZANINE_PCIX_MODE,
	output logic [7:0] CONTROL_FIRST,
	output logic [7:0] CONTROL_SECOND,
	output logic [1:0] WRITE_PROTECT_FLAGS,
	output logic [7:0] IRQ_ROUTING,
	output logic [7:0] WATCHDOG_CONTROL,
	output logic [7:0] LED_CONFIGURATION,
	output logic [7:0] LED_CONTROL,
	output logic [7:0] GENERAL_OUTPUTS
);
	import board_regs_pkg::*;

	logic [7:0] st_low_q, st_high_q, dbg_low_q, dbg_high_q;
	logic [7:0] board_control_first_q, board_control_second_q, irq_q, wdog_q, led_configuration_q, lctl_q, gpo_q;
	logic [1:0] prot_q;
	logic [7:0] rsrc_q;
	logic boot_done_q;
	logic [1:0] flash_q;
	logic [7:0] status_first;
	logic [7:0] rdata_d;
	logic hit_d;

	// ****************************************
	// Write strobes
	// ****************************************
	// One strobe per writable port; read-only and reserved ports raise none,
	// so host writes to them fall on the floor without any extra logic
	logic wr_st_low, wr_st_high, wr_dbg_low, wr_dbg_high;
	logic wr_board_control_first, wr_board_control_second, wr_prot, wr_rsrc, wr_irq;
	logic wr_wdog, wr_led_configuration, wr_lctl, wr_gpo;
	assign wr_st_low = IO_WR && (IO_ADDR == ADDR_SELFTEST_LOW);
	assign wr_st_high = IO_WR && (IO_ADDR == ADDR_SELFTEST_HIGH);
	assign wr_dbg_low = IO_WR && (IO_ADDR == ADDR_DEBUG_LOW);
	assign wr_dbg_high = IO_WR && (IO_ADDR == ADDR_DEBUG_HIGH);
	assign wr_board_control_first = IO_WR && (IO_ADDR == ADDR_CONTROL_FIRST);
	assign wr_board_control_second = IO_WR && (IO_ADDR == ADDR_CONTROL_SECOND);
	assign wr_prot = IO_WR && (IO_ADDR == ADDR_WRITE_PROTECT);
	assign wr_rsrc = IO_WR && (IO_ADDR == ADDR_RESET_SOURCE);
	assign wr_irq = IO_WR && (IO_ADDR == ADDR_IRQ_ROUTING);
	assign wr_wdog = IO_WR && (IO_ADDR == ADDR_WATCHDOG);
	assign wr_led_configuration = IO_WR && (IO_ADDR == ADDR_LED_CONFIG);
	assign wr_lctl = IO_WR && (IO_ADDR == ADDR_LED_CONTROL);
	assign wr_gpo = IO_WR && (IO_ADDR == ADDR_GP_OUTPUTS);

	// Self-test code low byte; 0x082-0x083 decode to nothing
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_low_q <= RST_ZERO;
		end else if (wr_st_low) begin
			st_low_q <= IO_WDATA;
		end
	end

	// Self-test code high byte
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_high_q <= RST_ZERO;
		end else if (wr_st_high) begin
			st_high_q <= IO_WDATA;
		end
	end

	// Debug low byte
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			dbg_low_q <= RST_ZERO;
		end else if (wr_dbg_low) begin
			dbg_low_q <= IO_WDATA;
		end
	end

	// Debug high byte
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			dbg_high_q <= RST_ZERO;
		end else if (wr_dbg_high) begin
			dbg_high_q <= IO_WDATA;
		end
	end

	// First control byte keeps its read-only bits at the reset pattern
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			board_control_first_q <= RST_CONTROL_FIRST;
		end else if (wr_board_control_first) begin
			board_control_first_q <= (IO_WDATA & BOARD_CONTROL_FIRST_WR_MASK) | (RST_CONTROL_FIRST & ~BOARD_CONTROL_FIRST_WR_MASK);
		end
	end

	// Second control byte, same masking so fixed bits cannot be disturbed
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			board_control_second_q <= RST_CONTROL_SECOND;
		end else if (wr_board_control_second) begin
			board_control_second_q <= (IO_WDATA & BOARD_CONTROL_SECOND_WR_MASK) | (RST_CONTROL_SECOND & ~BOARD_CONTROL_SECOND_WR_MASK);
		end
	end

	// Write protect flags are set-only: once armed they stay until reset
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			prot_q <= 2'h0;
		end else if (wr_prot) begin
			prot_q <= prot_q | IO_WDATA[PROT_EEPROM_BIT:PROT_SPI_BIT];
		end
	end

	// Reset source log: source bits clear on writing one, no-log bit plain
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rsrc_q <= RST_RESET_SOURCE;
		end else if (wr_rsrc) begin
			rsrc_q <= rsrc_q & ~(IO_WDATA & RSRC_W1C_MASK);
			rsrc_q[RSRC_NOLOG_BIT] <= IO_WDATA[RSRC_NOLOG_BIT];
		end
	end

	// Interrupt routing; the fixed field stays zero whatever is written
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			irq_q <= RST_ZERO;
		end else if (wr_irq) begin
			irq_q <= IO_WDATA & IRQ_WR_MASK;
		end
	end

	// Watchdog control byte, handed to the timer logic unchanged
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			wdog_q <= RST_ZERO;
		end else if (wr_wdog) begin
			wdog_q <= IO_WDATA;
		end
	end

	// LED configuration byte
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			led_configuration_q <= RST_ZERO;
		end else if (wr_led_configuration) begin
			led_configuration_q <= IO_WDATA;
		end
	end

	// LED control byte
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			lctl_q <= RST_ZERO;
		end else if (wr_lctl) begin
			lctl_q <= IO_WDATA;
		end
	end

	// General output byte, driven straight to the output pins
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			gpo_q <= RST_ZERO;
		end else if (wr_gpo) begin
			gpo_q <= IO_WDATA;
		end
	end

	// ****************************************
	// Boot state
	// ****************************************
	// Boot-done is sticky until reset; firmware marks it, host cannot clear it
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			boot_done_q <= 1'b0;
		end else if (FIRMWARE_BOOT_DONE) begin
			boot_done_q <= 1'b1;
		end
	end

	// Strap two wins over controller requests, so a recovery boot holds while the strap is on
	// With the strap off a request may pick any source, the reserved code included
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			flash_q <= FLASH_STANDARD;
		end else if (BOOT_STRAP_TWO) begin
			flash_q <= FLASH_RECOVERY;
		end else if (FLASH_SELECT_REQ) begin
			flash_q <= FLASH_SELECT_VALUE;
		end else if (flash_q == FLASH_RECOVERY) begin
			flash_q <= FLASH_STANDARD;
		end
	end

	// ****************************************
	// Status and strap outputs
	// ****************************************
	// Handle and boot straps are live; no latching so software sees motion
	// Boot-done and the flash field are the only stored bits in this byte
	always_comb begin
		status_first = {EJECTOR_HANDLE_OPEN, boot_done_q, flash_q,
			BOOT_STRAP_FOUR, BOOT_STRAP_THREE, BOOT_STRAP_TWO, BOOT_STRAP_ONE};
	end

	// Backplane speed, registered for a glitch-free output; switch on forces slow
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			BACKPLANE_CLK_66 <= 1'b0;
		end else begin
			BACKPLANE_CLK_66 <= !BACKPLANE_SWITCH_ONE && BACKPLANE_66_DETECT;
		end
	end

	// Backplane mode; switch on forces conventional mode whatever is detected
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			BACKPLANE_PCIX_MODE <= 1'b0;
		end else begin
			BACKPLANE_PCIX_MODE <= !BACKPLANE_SWITCH_TWO && BACKPLANE_PCIX_DETECT;
		end
	end

	// Mezzanine multiplier base follows its switch directly
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			MEZZANINE_BASE_25 <= 1'b0;
		end else begin
			MEZZANINE_BASE_25 <= MEZZANINE_SWITCH_ONE;
		end
	end

	// Mezzanine mode; switch on forces conventional mode over the module's report
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			MEZZANINE_PCIX_MODE <= 1'b0;
		end else begin
			MEZZANINE_PCIX_MODE <= !MEZZANINE_SWITCH_TWO && MEZZANINE_PCIX_DETECT;
		end
	end

	// Self-test display enable; strap one on hides the codes from the LEDs
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			SELFTEST_DISPLAY_EN <= 1'b0;
		end else begin
			SELFTEST_DISPLAY_EN <= !BOOT_STRAP_ONE;
		end
	end

	// ****************************************
	// Read decode
	// ****************************************
	// Unlisted ports answer zero and no hit
	// Decode compares all 16 address bits, so no port appears at an alias
	// Masks here hide the reserved bits of the live status inputs
	always_comb begin
		rdata_d = RST_ZERO;
		hit_d = 1'b1;
		unique case (IO_ADDR)
			ADDR_SELFTEST_LOW: rdata_d = st_low_q;
			ADDR_SELFTEST_HIGH: rdata_d = st_high_q;
			ADDR_DEBUG_LOW: rdata_d = dbg_low_q;
			ADDR_DEBUG_HIGH: rdata_d = dbg_high_q;
			ADDR_STATUS_FIRST: rdata_d = status_first;
			ADDR_STATUS_SECOND: rdata_d = BACKPLANE_STATUS & 8'hEF;
			ADDR_CONTROL_FIRST: rdata_d = board_control_first_q;
			ADDR_CONTROL_SECOND: rdata_d = board_control_second_q;
			ADDR_WRITE_PROTECT: rdata_d = {SYS_WRITE_PROTECT, 5'h00, prot_q};
			ADDR_RESET_SOURCE: rdata_d = rsrc_q;
			ADDR_IRQ_ROUTING: rdata_d = irq_q;
			ADDR_STATUS_THIRD: rdata_d = BOARD_STATUS_THIRD & BOARD_STATUS_THIRD_MASK;
			ADDR_TYPE_HIGH: rdata_d = BOARD_TYPE_CODE[15:8];
			ADDR_REVISION: rdata_d = REVISION_CODE;
			ADDR_SLOT_SITE: rdata_d = {3'h0, SLOT_SITE_NUMBER} & SLOT_MASK;
			ADDR_WATCHDOG: rdata_d = wdog_q;
			ADDR_TYPE_LOW: rdata_d = BOARD_TYPE_CODE[7:0];
			ADDR_LED_CONFIG: rdata_d = led_configuration_q;
			ADDR_LED_CONTROL: rdata_d = lctl_q;
			ADDR_GP_OUTPUTS: rdata_d = gpo_q;
			ADDR_GP_INPUTS: rdata_d = GENERAL_INPUTS;
			default: hit_d = 1'b0;
		endcase
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			IO_RDATA <= RST_ZERO;
			IO_HIT <= 1'b0;
		end else begin
			IO_RDATA <= (IO_RD && hit_d) ? rdata_d : RST_ZERO;
			IO_HIT <= IO_RD && hit_d;
		end
	end

	// Register contents driven to board logic
	// Outputs come straight from the flip-flops, so they never glitch
	assign BOOT_FLASH_SELECTED = flash_q;
	assign SELFTEST_CODE = {st_high_q, st_low_q};
	assign DEBUG_WORD = {dbg_high_q, dbg_low_q};
	assign CONTROL_FIRST = board_control_first_q;
	assign CONTROL_SECOND = board_control_second_q;
	assign WRITE_PROTECT_FLAGS = prot_q;
	assign IRQ_ROUTING = irq_q;
	assign WATCHDOG_CONTROL = wdog_q;
	assign LED_CONFIGURATION = led_configuration_q;
	assign LED_CONTROL = lctl_q;
	assign GENERAL_OUTPUTS = gpo_q;

endmodule : board_control_status_registers

// ---- test/board_regs_props.sv ----
// Checker for the board register bank, bound to the top-level ports.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module board_regs_props
	import board_regs_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [7:0] IO_WDATA,
	input wire logic [7:0] IO_RDATA,
	input wire logic IO_HIT,
	input wire logic EJECTOR_HANDLE_OPEN,
	input wire logic BOOT_STRAP_ONE,
	input wire logic BOOT_STRAP_TWO,
	input wire logic BOOT_STRAP_THREE,
	input wire logic BOOT_STRAP_FOUR,
	input wire logic BACKPLANE_SWITCH_ONE,
	input wire logic BACKPLANE_66_DETECT,
	input wire logic MEZZANINE_SWITCH_ONE,
	input wire logic [1:0] BOOT_FLASH_SELECTED,
	input wire logic SELFTEST_DISPLAY_EN,
	input wire logic BACKPLANE_CLK_66,
	input wire logic MEZZANINE_BASE_25,
	input wire logic [7:0] GENERAL_OUTPUTS
);
	// Live pins as seen at the read edge; one vector so $past sees a plain signal
	wire logic [4:0] pins = {EJECTOR_HANDLE_OPEN, BOOT_STRAP_FOUR, BOOT_STRAP_THREE,
		BOOT_STRAP_TWO, BOOT_STRAP_ONE};
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// ****************************************
	// Assertions
	// ****************************************
	sequence status_read;
		IO_RD && IO_ADDR == ADDR_STATUS_FIRST;
	endsequence
	sequence gap_read;
		IO_RD && IO_ADDR == 16'h028B;
	endsequence
	a_status_pin_bits: assert property (status_read |=> IO_HIT &&
		{IO_RDATA[7], IO_RDATA[3:0]} == $past(pins)) else $error("status pins misreported");
	a_gap_read_zero: assert property (gap_read |=> IO_RDATA == 8'h00 && !IO_HIT)
		else $error("reserved port answered");
	a_read_data_idle: assert property (!IO_RD |=> IO_RDATA == 8'h00 && !IO_HIT)
		else $error("read data without a read");
	a_strap_forces_recovery: assert property (BOOT_STRAP_TWO |=>
		BOOT_FLASH_SELECTED == FLASH_RECOVERY) else $error("flash not forced to recovery");
	a_display_follows_strap: assert property (1'b1 |=>
		SELFTEST_DISPLAY_EN == !$past(BOOT_STRAP_ONE)) else $error("display enable wrong");
	a_forced_slow_clock: assert property (1'b1 |=> BACKPLANE_CLK_66 ==
		(!$past(BACKPLANE_SWITCH_ONE) && $past(BACKPLANE_66_DETECT))) else $error("clock wrong");
	a_mezz_base_follows: assert property (1'b1 |=>
		MEZZANINE_BASE_25 == $past(MEZZANINE_SWITCH_ONE)) else $error("base select wrong");
	a_gp_output_write: assert property (IO_WR && IO_ADDR == ADDR_GP_OUTPUTS |=>
		GENERAL_OUTPUTS == $past(IO_WDATA)) else $error("general outputs not written");
endmodule : board_regs_props

bind board_control_status_registers board_regs_props u_props (.SYS_CLK(SYS_CLK), .RST(RST),
	.IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
	.IO_HIT(IO_HIT), .EJECTOR_HANDLE_OPEN(EJECTOR_HANDLE_OPEN), .BOOT_STRAP_ONE(BOOT_STRAP_ONE),
	.BOOT_STRAP_TWO(BOOT_STRAP_TWO), .BOOT_STRAP_THREE(BOOT_STRAP_THREE),
	.BOOT_STRAP_FOUR(BOOT_STRAP_FOUR), .BACKPLANE_SWITCH_ONE(BACKPLANE_SWITCH_ONE),
	.BACKPLANE_66_DETECT(BACKPLANE_66_DETECT), .MEZZANINE_SWITCH_ONE(MEZZANINE_SWITCH_ONE),
	.BOOT_FLASH_SELECTED(BOOT_FLASH_SELECTED), .SELFTEST_DISPLAY_EN(SELFTEST_DISPLAY_EN),
	.BACKPLANE_CLK_66(BACKPLANE_CLK_66), .MEZZANINE_BASE_25(MEZZANINE_BASE_25),
	.GENERAL_OUTPUTS(GENERAL_OUTPUTS));

// ---- test/io_host_model.sv ----
// Host chipset model issuing byte-wide I/O port cycles.
// Assumes strobes are launched on the falling clock edge.
`timescale 1ns/1ps
module io_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] io_rdata,
	input wire logic io_hit,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	// Idle bus from time zero
	initial begin
		io_addr = 16'hFFFF;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// Released lines are inverted so a stale address or byte is never mistaken for a fresh one
	task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
		@(negedge sys_clk);
		io_addr = addr;
		io_wdata = data;
		io_wr = 1'b1;
		@(negedge sys_clk);
		io_wr = 1'b0;
		io_addr = ~addr;
		io_wdata = ~data;
	endtask : io_write
	// Data stands for one cycle after the read edge, so take it at the next falling edge
	task automatic io_read(input logic [15:0] addr, output logic [7:0] data, output logic hit);
		@(negedge sys_clk);
		io_addr = addr;
		io_rd = 1'b1;
		@(negedge sys_clk);
		io_rd = 1'b0;
		io_addr = ~addr;
		data = io_rdata;
		hit = io_hit;
	endtask : io_read
endmodule : io_host_model

// ---- test/board_control_status_registers_test.sv ----
// Self-checking bench for the board register bank.
// Assumes the host model drives every I/O cycle; pins change at the falling edge.
`timescale 1ns/1ps
module board_control_status_registers_test;
	import board_regs_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] io_addr, post_code, debug_word;
	logic io_wr, io_rd, io_hit, disp_en, clk66, bp_pcix, mz_base25, mz_pcix;
	logic [7:0] io_wdata, io_rdata, gp_out, ctl0, ctl1, irq_out, wdog_out, led_configuration_out, lctl_out;
	logic [1:0] flash_sel, wp_flags;
	logic [7:0] gp_in = 8'hC3;
	logic [1:0] flash_val = FLASH_EXTERNAL;
	logic [3:0] straps = 4'h0;
	logic [3:0] sw = 4'h0;
	logic [2:0] det = 3'h7;
	logic handle = 1'b0;
	logic boot_done = 1'b0;
	logic flash_req = 1'b0;
	int miscompares = 0;
	int n_compared = 0;
	localparam logic [15:0] RW_ADDR [8] = '{ADDR_SELFTEST_LOW, ADDR_SELFTEST_HIGH, ADDR_DEBUG_LOW,
		ADDR_DEBUG_HIGH, ADDR_WATCHDOG, ADDR_LED_CONFIG, ADDR_LED_CONTROL, ADDR_GP_OUTPUTS};
	localparam logic [15:0] GAP_ADDR [7] = '{16'h0082, 16'h0083, 16'h028B, 16'h028E, 16'h028F,
		16'h0294, 16'h029C};
	localparam logic [15:0] RO_ADDR [7] = '{ADDR_STATUS_SECOND, ADDR_STATUS_THIRD, ADDR_TYPE_HIGH,
		ADDR_REVISION, ADDR_SLOT_SITE, ADDR_TYPE_LOW, ADDR_GP_INPUTS};
	localparam logic [7:0] RO_EXP [7] = '{8'h4A, 8'h02, 8'h3C, 8'h2B, 8'h13, 8'h7E, 8'hC3};
	localparam logic [15:0] RST_ADDR [5] = '{ADDR_CONTROL_FIRST, ADDR_CONTROL_SECOND,
		ADDR_WRITE_PROTECT, ADDR_RESET_SOURCE, ADDR_IRQ_ROUTING};
	localparam logic [7:0] RST_EXP [5] = '{8'hC4, 8'hC4, 8'h80, 8'h80, 8'h00};
	// Board type code is arbitrary
	board_control_status_registers #(.BOARD_TYPE_CODE(16'h3C7E), .REVISION_CODE(8'h2B)) uut (
		.SYS_CLK(sys_clk), .RST(rst), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
		.IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_HIT(io_hit), .EJECTOR_HANDLE_OPEN(handle),
		.BOOT_STRAP_ONE(straps[0]), .BOOT_STRAP_TWO(straps[1]), .BOOT_STRAP_THREE(straps[2]),
		.BOOT_STRAP_FOUR(straps[3]), .BACKPLANE_SWITCH_ONE(sw[0]), .BACKPLANE_SWITCH_TWO(sw[1]),
		.MEZZANINE_SWITCH_ONE(sw[2]), .MEZZANINE_SWITCH_TWO(sw[3]), .BACKPLANE_66_DETECT(det[0]),
		.BACKPLANE_PCIX_DETECT(det[1]), .MEZZANINE_PCIX_DETECT(det[2]), .BACKPLANE_STATUS(8'h5A),
		.BOARD_STATUS_THIRD(8'hFF), .SLOT_SITE_NUMBER(5'h13), .SYS_WRITE_PROTECT(1'b1),
		.GENERAL_INPUTS(gp_in), .FIRMWARE_BOOT_DONE(boot_done), .FLASH_SELECT_REQ(flash_req),
		.FLASH_SELECT_VALUE(flash_val), .BOOT_FLASH_SELECTED(flash_sel),
		.SELFTEST_DISPLAY_EN(disp_en), .SELFTEST_CODE(post_code), .DEBUG_WORD(debug_word),
		.BACKPLANE_CLK_66(clk66), .BACKPLANE_PCIX_MODE(bp_pcix), .MEZZANINE_BASE_25(mz_base25),
		.MEZZANINE_PCIX_MODE(mz_pcix), .CONTROL_FIRST(ctl0), .CONTROL_SECOND(ctl1),
		.WRITE_PROTECT_FLAGS(wp_flags), .IRQ_ROUTING(irq_out), .WATCHDOG_CONTROL(wdog_out),
		.LED_CONFIGURATION(led_configuration_out), .LED_CONTROL(lctl_out), .GENERAL_OUTPUTS(gp_out));
	io_host_model host (.sys_clk(sys_clk), .io_rdata(io_rdata), .io_hit(io_hit),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
	// 50 MHz clock
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// A read that must hit and return the given byte
	task automatic rd_check(input logic [15:0] addr, input logic [7:0] exp);
		logic [7:0] data;
		logic seen_hit;
		host.io_read(addr, data, seen_hit);
		check({seen_hit, 7'h00, data}, {1'b1, 7'h00, exp});
	endtask : rd_check
	task automatic print_verdict();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict
	// Cuts a hang short
	initial begin
		#1000000;
		miscompares++;
		print_verdict();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] rd;
		logic hit;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) rd_check(RST_ADDR[i], RST_EXP[i]);
		check({ctl0, ctl1}, 16'hC4C4);
		check({6'h00, wp_flags, irq_out}, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			rd_check(RO_ADDR[i], RO_EXP[i]);
			host.io_write(RO_ADDR[i], ~RO_EXP[i]);
			rd_check(RO_ADDR[i], RO_EXP[i]);
		end
		gp_in = 8'h3C;
		rd_check(ADDR_GP_INPUTS, 8'h3C);
		for (int i = 0; i < 7; i++) begin
			host.io_write(GAP_ADDR[i], 8'hFF);
			host.io_read(GAP_ADDR[i], rd, hit);
			check({hit, 7'h00, rd}, 16'h0000);
		end
		for (int i = 0; i < 8; i++) host.io_write(RW_ADDR[i], RW_ADDR[i][7:0] ^ 8'hA5);
		for (int i = 0; i < 8; i++) rd_check(RW_ADDR[i], RW_ADDR[i][7:0] ^ 8'hA5);
		check(post_code, 16'h2425);
		check(debug_word, 16'h2021);
		check(gp_out, 8'h37);
		check({wdog_out, led_configuration_out}, 16'h2935);
		check(lctl_out, 8'h34);
		// Mixed registers: only the writable bits take a written one
		host.io_write(ADDR_CONTROL_FIRST, 8'hFF);
		host.io_write(ADDR_CONTROL_SECOND, 8'hFF);
		host.io_write(ADDR_IRQ_ROUTING, 8'hFF);
		rd_check(ADDR_CONTROL_FIRST, 8'hCC);
		rd_check(ADDR_CONTROL_SECOND, 8'hDF);
		rd_check(ADDR_IRQ_ROUTING, 8'hF3);
		check({ctl0, ctl1}, 16'hCCDF);
		check(irq_out, 8'hF3);
		// Protection bits only set; power-on flag clears on a one
		host.io_write(ADDR_WRITE_PROTECT, 8'h03);
		host.io_write(ADDR_WRITE_PROTECT, 8'h00);
		rd_check(ADDR_WRITE_PROTECT, 8'h83);
		check(wp_flags, 2'h3);
		host.io_write(ADDR_RESET_SOURCE, 8'hA0);
		rd_check(ADDR_RESET_SOURCE, 8'h20);
		for (int i = 0; i < 16; i++) begin
			@(negedge sys_clk);
			straps = i[3:0];
			handle = ~i[1];
			rd_check(ADDR_STATUS_FIRST, {~i[1], 2'b00, i[1], i[3:0]});
			check(disp_en, !i[0]);
		end
		// Request while strap two is on must be ignored
		@(negedge sys_clk);
		flash_req = 1'b1;
		@(negedge sys_clk);
		flash_req = 1'b0;
		rd_check(ADDR_STATUS_FIRST, 8'h1F);
		@(negedge sys_clk);
		straps = 4'hD;
		rd_check(ADDR_STATUS_FIRST, 8'h0D);
		@(negedge sys_clk);
		flash_req = 1'b1;
		boot_done = 1'b1;
		handle = 1'b1;
		@(negedge sys_clk);
		flash_req = 1'b0;
		boot_done = 1'b0;
		rd_check(ADDR_STATUS_FIRST, 8'hED);
		// Boot-done must stay set after its pulse; a new request picks standard
		@(negedge sys_clk);
		flash_val = FLASH_STANDARD;
		flash_req = 1'b1;
		@(negedge sys_clk);
		flash_req = 1'b0;
		rd_check(ADDR_STATUS_FIRST, 8'hCD);
		check(flash_sel, 2'h0);
		for (int i = 0; i < 16; i++) begin
			@(negedge sys_clk);
			sw = i[3:0];
			det = i[2:0] ^ 3'h5;
			@(negedge sys_clk);
			check({clk66, bp_pcix, mz_base25, mz_pcix}, {!sw[0] & det[0], !sw[1] & det[1], sw[2],
				!sw[3] & det[2]});
		end
		print_verdict();
	end
endmodule : board_control_status_registers_test
